// ---- rtl/step2_cfg.sv ----
`timescale 1ns/1ps
`default_nettype none
module step2_cfg
   import step2_cfg_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic step_enable_bit,
   output logic [1:0] step_gain_select,
   output logic step_negative_input_select,
   output logic [3:0] step_positive_input_select,
   output var step2_cfg_pkg::step_route_t step_route
);
   import step2_cfg_pkg::*;

   logic [15:0] cfg_r;
   logic [31:0] awaddr_r;
   logic aw_held_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic w_held_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   step_route_t route_r;

   // a write is performed once both address and data are held and no response is pending
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire wr_fire = aw_held_r && w_held_r && !bvalid_r;
   wire wr_hit = awaddr_r[31:2] == {22'h0, CFG_ADDR[7:0]};
   wire rd_hit = s_axi_araddr[31:2] == {22'h0, CFG_ADDR[7:0]};
   wire ar_take = s_axi_arvalid && s_axi_arready;
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

   // register index sits at word address 92h; byte lanes 0 and 1 hold the 16 bits
   wire [15:0] lane_mask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   wire [15:0] wr_mask = lane_mask & CFG_WMASK;
   wire [15:0] cfg_nxt = (cfg_r & ~wr_mask) | (wdata_r[15:0] & wr_mask);

   // gain decode: both upper codes mean gain 4
   wire [2:0] gain_dec = (cfg_r[GAIN_HI:GAIN_LO] == 2'h0) ? GAIN_X1 :
                         (cfg_r[GAIN_HI:GAIN_LO] == 2'h1) ? GAIN_X2 : GAIN_X4;
   wire pos_internal = cfg_r[POS_HI:0] >= POS_AUTO_MIN;
   wire neg_sel_t neg_dec = pos_internal ? NEG_AUTO :
                            (cfg_r[NEG_BIT] ? NEG_EXT7 : NEG_GROUND);
   step_route_t route_nxt;
   always_comb
   begin
      route_nxt = '0;
      route_nxt.neg = NEG_GROUND;
      if (cfg_r[EN_BIT])
      begin
         route_nxt.active = 1'b1;
         route_nxt.gain = gain_dec;
         route_nxt.pos_code = cfg_r[POS_HI:0];
         route_nxt.neg = neg_dec;
      end
   end

   // raw field views straight from the register
   assign step_enable_bit = cfg_r[EN_BIT];
   assign step_gain_select = cfg_r[GAIN_HI:GAIN_LO];
   assign step_negative_input_select = cfg_r[NEG_BIT];
   assign step_positive_input_select = cfg_r[POS_HI:0];
   assign step_route = route_r;

   // configuration storage
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cfg_r <= CFG_RESET;
      else if (wr_fire && wr_hit)
         cfg_r <= cfg_nxt;
   end

   // registered routing, one cycle behind the register so glitches never reach the mux
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         route_r <= '0;
      else
         route_r <= route_nxt;
   end

   // write address and data latches, taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 32'h0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
      end
      else
      begin
         if (aw_take)
         begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         else if (wr_fire)
            aw_held_r <= 1'b0;
         if (w_take)
         begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_held_r <= 1'b0;
      end
   end

   // write response; unmapped addresses answer slverr and change nothing
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_r <= 1'b0;
   end

   // read channel; reserved bits come back zero from storage
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= 32'h0;
      end
      else if (ar_take)
      begin
         rvalid_r <= 1'b1;
         rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         rdata_r <= rd_hit ? {16'h0, cfg_r} : 32'h0;
      end
      else if (s_axi_rready)
         rvalid_r <= 1'b0;
   end

   // checks
   property p_reserved_zero;
      @(posedge aclk) disable iff (!aresetn)
      cfg_r[12:5] == 8'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

   property p_reset_value;
      @(posedge aclk) !aresetn |=> cfg_r == CFG_RESET;
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("bad reset value");

   property p_disabled_idle;
      @(posedge aclk) disable iff (!aresetn)
      !cfg_r[EN_BIT] |=> !route_r.active && route_r.gain == 3'h0;
   endproperty
   a_disabled_idle: assert property (p_disabled_idle) else $error("disabled step applied");

   property p_enable_active;
      @(posedge aclk) disable iff (!aresetn)
      cfg_r[EN_BIT] |=> route_r.active && route_r.pos_code == $past(cfg_r[3:0]);
   endproperty
   a_enable_active: assert property (p_enable_active) else $error("enabled step not routed");

   property p_gain4;
      @(posedge aclk) disable iff (!aresetn)
      cfg_r[EN_BIT] && cfg_r[14] |=> route_r.gain == GAIN_X4;
   endproperty
   a_gain4: assert property (p_gain4) else $error("gain code not 4");

   property p_gain2;
      @(posedge aclk) disable iff (!aresetn)
      cfg_r[EN_BIT] && cfg_r[14:13] == 2'h1 |=> route_r.gain == GAIN_X2;
   endproperty
   a_gain2: assert property (p_gain2) else $error("gain code not 2");

   property p_neg_manual;
      @(posedge aclk) disable iff (!aresetn)
      cfg_r[EN_BIT] && !cfg_r[3] |=> route_r.neg == ($past(cfg_r[NEG_BIT]) ? NEG_EXT7 : NEG_GROUND);
   endproperty
   a_neg_manual: assert property (p_neg_manual) else $error("negative select wrong");

   property p_neg_auto;
      @(posedge aclk) disable iff (!aresetn)
      cfg_r[EN_BIT] && cfg_r[3] |=> route_r.neg == NEG_AUTO;
   endproperty
   a_neg_auto: assert property (p_neg_auto) else $error("negative not automatic");

   sequence s_write_hit;
      wr_fire && wr_hit && wstrb_r[0];
   endsequence
   property p_write_pos;
      @(posedge aclk) disable iff (!aresetn)
      s_write_hit |=> cfg_r[3:0] == $past(wdata_r[3:0]) ##1 s_axi_bvalid || $past(s_axi_bready);
   endproperty
   a_write_pos: assert property (p_write_pos) else $error("write not stored");

   // the upper byte lane carries enable and gain, so it is checked apart from the lower lane
   sequence s_write_upper;
      wr_fire && wr_hit && wstrb_r[1];
   endsequence

   // a read that lands on the configuration word
   sequence s_read_hit;
      ar_take && rd_hit;
   endsequence

   property p_write_enable;
      @(posedge aclk) disable iff (!aresetn)
      s_write_upper |=> cfg_r[EN_BIT] == $past(wdata_r[EN_BIT]);
   endproperty
   a_write_enable: assert property (p_write_enable) else $error("enable bit not stored");

   property p_write_gain;
      @(posedge aclk) disable iff (!aresetn)
      s_write_upper |=> cfg_r[GAIN_HI:GAIN_LO] == $past(wdata_r[GAIN_HI:GAIN_LO]);
   endproperty
   a_write_gain: assert property (p_write_gain) else $error("gain field not stored");

   property p_write_neg;
      @(posedge aclk) disable iff (!aresetn)
      s_write_hit |=> cfg_r[NEG_BIT] == $past(wdata_r[NEG_BIT]);
   endproperty
   a_write_neg: assert property (p_write_neg) else $error("negative select not stored");

   // a write with neither low lane strobed must leave the word alone
   property p_strobe_none;
      @(posedge aclk) disable iff (!aresetn)
      wr_fire && wr_hit && wstrb_r[1:0] == 2'h0 |=> $stable(cfg_r);
   endproperty
   a_strobe_none: assert property (p_strobe_none) else $error("unstrobed write changed register");

   property p_unmapped_keep;
      @(posedge aclk) disable iff (!aresetn)
      wr_fire && !wr_hit |=> $stable(cfg_r) && s_axi_bresp == RESP_SLVERR;
   endproperty
   a_unmapped_keep: assert property (p_unmapped_keep) else $error("unmapped write changed register");

   property p_read_value;
      @(posedge aclk) disable iff (!aresetn)
      s_read_hit |=> s_axi_rdata == {16'h0, $past(cfg_r)} && s_axi_rresp == RESP_OKAY;
   endproperty
   a_read_value: assert property (p_read_value) else $error("read data differs from register");

   property p_read_reserved;
      @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> s_axi_rdata[12:5] == 8'h0;
   endproperty
   a_read_reserved: assert property (p_read_reserved) else $error("reserved bits read nonzero");

   property p_unmapped_read;
      @(posedge aclk) disable iff (!aresetn)
      ar_take && !rd_hit |=> s_axi_rdata == 32'h0 && s_axi_rresp == RESP_SLVERR;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not refused");

   property p_gain1;
      @(posedge aclk) disable iff (!aresetn)
      cfg_r[EN_BIT] && cfg_r[GAIN_HI:GAIN_LO] == 2'h0 |=> route_r.gain == GAIN_X1;
   endproperty
   a_gain1: assert property (p_gain1) else $error("gain code not 1");

   property p_disabled_neg;
      @(posedge aclk) disable iff (!aresetn)
      !cfg_r[EN_BIT] |=> route_r.neg == NEG_GROUND && route_r.pos_code == 4'h0;
   endproperty
   a_disabled_neg: assert property (p_disabled_neg) else $error("disabled step routes inputs");

   // answers come one cycle after the request is complete and block new requests
   property p_write_answer;
      @(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("write response missing");

   property p_read_answer;
      @(posedge aclk) disable iff (!aresetn)
      ar_take |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read response missing");

   property p_reset_outputs;
      @(posedge aclk) !aresetn |=> route_r == '0 && !s_axi_bvalid && !s_axi_rvalid;
   endproperty
   a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not idle after reset");
endmodule
`default_nettype wire

// ---- rtl/step2_cfg_pkg.sv ----
package step2_cfg_pkg;
   localparam logic [7:0] CFG_ADDR = 8'h92;
   localparam logic [15:0] CFG_RESET = 16'h0002;
   localparam logic [15:0] CFG_WMASK = 16'he01f;
   localparam int EN_BIT = 15;
   localparam int GAIN_HI = 14;
   localparam int GAIN_LO = 13;
   localparam int NEG_BIT = 4;
   localparam int POS_HI = 3;
   localparam logic [3:0] POS_AUTO_MIN = 4'h8;
   localparam logic [2:0] GAIN_X1 = 3'h1;
   localparam logic [2:0] GAIN_X2 = 3'h2;
   localparam logic [2:0] GAIN_X4 = 3'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      NEG_GROUND,
      NEG_EXT7,
      NEG_AUTO
   } neg_sel_t;

   // routing handed to the sequencer for this step
   typedef struct packed {
      logic active;
      logic [2:0] gain;
      logic [3:0] pos_code;
      neg_sel_t neg;
   } step_route_t;
endpackage

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import step2_cfg_pkg::*;
   logic aclk, awready, wready, bvalid, arready, rvalid, en, neg;
   logic aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, d;
   logic [3:0] wstrb = '0, pos, s;
   logic [1:0] bresp, rresp, gain, r;
   logic [15:0] model;
   step_route_t route;
   int fails, tests_run;
   // register index 92h is a word address, so the byte address is four times it
   localparam logic [31:0] A = {22'h0, CFG_ADDR, 2'b00};

   step2_cfg dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .step_enable_bit(en),
      .step_gain_select(gain), .step_negative_input_select(neg), .step_positive_input_select(pos),
      .step_route(route));

   // 50 mhz clock
   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // write: address and data offered together, each released when taken
   task automatic wr(input logic [31:0] a, input logic [31:0] dv, input logic [3:0] sv, output logic [1:0] rv);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      awaddr <= a;
      wdata <= dv;
      wstrb <= sv;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ta && tw))
      begin
         @(posedge aclk);
         if (!ta && awready)
         begin
            ta = 1'b1;
            awvalid <= 1'b0;
         end
         if (!tw && wready)
         begin
            tw = 1'b1;
            wvalid <= 1'b0;
         end
      end
      // raised only after the edge so a back-to-back call never lowers and raises it at once
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      rv = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] dv, output logic [1:0] rv);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      dv = rdata;
      rv = rresp;
      rready <= 1'b0;
   endtask

   // expected sequencer routing; disabled step hands on nothing at all
   function automatic step_route_t rt(input logic [15:0] c);
      step_route_t t;
      t = '0;
      if (c[15])
      begin
         t.active = 1'b1;
         t.gain = (c[14:13] == 2'h0) ? GAIN_X1 : (c[14:13] == 2'h1) ? GAIN_X2 : GAIN_X4;
         t.pos_code = c[3:0];
         t.neg = c[3] ? NEG_AUTO : (c[4] ? NEG_EXT7 : NEG_GROUND);
      end
      return t;
   endfunction

   // read back and compare every output against the model
   task automatic chk_out();
      logic [31:0] dv;
      logic [1:0] rv;
      rd(A, dv, rv);
      chk("cfg", dv, {16'h0, model});
      chk("rresp", 32'(rv), 32'(RESP_OKAY));
      chk("fields", 32'({en, gain, neg, pos}), 32'({model[15:13], model[4:0]}));
      chk("route", 32'(route), 32'(rt(model)));
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge aclk);
      fails++;
      report_and_stop();
   end

   // main sequence: reset value, every code, random strobes, unmapped place
   initial
   begin
      void'($urandom(32'h06b8));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      model = CFG_RESET;
      chk_out();
      $display("test reset done");
      for (int i = 0; i < 60; i++)
      begin
         d = $urandom;
         s = (i < 32) ? 4'h3 : 4'($urandom);
         if (i < 32)
         begin
            d[15] = 1'b1;
            d[14:13] = i[1:0];
            d[4:0] = i[4:0];
         end
         wr(A, d, s, r);
         chk("bresp", 32'(r), 32'(RESP_OKAY));
         if (s[0])
            model[7:0] = d[7:0] & CFG_WMASK[7:0];
         if (s[1])
            model[15:8] = d[15:8] & CFG_WMASK[15:8];
         chk_out();
      end
      $display("test codes and strobes done");
      wr(A + 32'h4, $urandom, 4'hf, r);
      chk("bresp unmapped", 32'(r), 32'(RESP_SLVERR));
      rd(A + 32'h4, d, r);
      chk("rresp unmapped", 32'(r), 32'(RESP_SLVERR));
      chk("rdata unmapped", d, 32'h0);
      chk_out();
      $display("test unmapped done");
      // second reset in mid-run must bring back the reset value over written contents
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      model = CFG_RESET;
      chk_out();
      $display("test reset again done");
      report_and_stop();
   end
endmodule
`default_nettype wire
